// >>> include/fspi_pkg.sv
// shared constants and carrier types for the coprocessor slave port
package fspi_pkg;
	localparam logic [3:0] ST_ID = 4'hf;
	localparam logic [3:0] ST_OP = 4'hd;
	localparam logic [3:0] ST_STAT = 4'he;
	localparam logic [1:0] PSEL_16 = 2'h0;
	localparam logic [1:0] PSEL_A = 2'h1;
	localparam logic [1:0] PSEL_B = 2'h3;
	localparam int SW_TRAP_BIT = 0;
	localparam int SW_L_BIT = 2;
	localparam int SW_EQ_BIT = 6;
	localparam int SW_LT_BIT = 7;
	localparam int SW_KIND_BIT = 15;
	localparam logic [31:0] SW_RESET = 32'h0000_0000;
	localparam logic [7:0] ID_DEFAULT = 8'hbe;
	localparam logic [3:0] OPC_CMP = 4'h2;
	localparam logic [3:0] OPC_LOAD_STATUS = 4'h1;
	localparam logic [3:0] OPC_STORE_STATUS = 4'h6;
	localparam logic [3:0] OPC_DOT = 4'h8;
	localparam logic [3:0] OPC_POLY = 4'h9;
	localparam logic [3:0] OPC_ILLEGAL = 4'hf;
	localparam int ADDR_MODE_REG = 0;
	localparam int SDN_A_LONG_HALF = 5;
	localparam int EXEC_CYCLES = 4;

	typedef struct packed {
		logic [7:0] id;
		logic [15:0] opword;
	} fspi_instr_s;

	typedef struct packed {
		logic [31:0] word;
		logic trap;
		logic kind;
		logic eq;
		logic lt;
	} fspi_result_s;
endpackage

// >>> rtl/fspi_slave.sv
// coprocessor slave protocol engine, 16-bit and 32-bit variants
`timescale 1ns/1ps
// =====================================================================
module fspi_slave
	import fspi_pkg::*;
#(
	parameter logic [7:0] OWN_ID = ID_DEFAULT // arbitrary value
) (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic [1:0] proto_sel,
	input wire logic slave_strobe_n_in,
	output logic slave_strobe_n_out,
	output logic slave_strobe_oe,
	input wire logic [3:0] status_code,
	input wire logic [31:0] data_in,
	output logic [31:0] data_out,
	output logic data_oe,
	output logic done_pulse_variant_a_n,
	output logic done_pulse_variant_b_n,
	output logic forced_status_read_n,
	output logic [63:0] accumulator_reg
);
	// phases follow the host's transfer order; an ID transfer can leave any of them
	typedef enum {PH_IDLE, PH_OPWORD, PH_OPND, PH_EXEC, PH_DONE, PH_STAT, PH_RES} fspi_ph_e;

	// number of operand words the host will send for this opword
	function automatic logic [2:0] opnd_words(input logic [15:0] ow, input logic w32);
		logic [2:0] per;
		logic [2:0] n;
		per = 3'h0;
		n = 3'h0;
		if (ow[3:0] == OPC_LOAD_STATUS || ow[3:0] == OPC_STORE_STATUS)
			per = w32 ? 3'h1 : 3'h2;
		else
			per = ow[4] ? (w32 ? 3'h2 : 3'h4) : (w32 ? 3'h1 : 3'h2);
		if (ow[3:0] != OPC_STORE_STATUS && ow[7:5] != 3'(ADDR_MODE_REG))
			n = per;
		if (ow[3:0] != OPC_LOAD_STATUS && ow[3:0] != OPC_STORE_STATUS &&
			ow[10:8] != 3'(ADDR_MODE_REG))
			n = 3'(n + per);
		opnd_words = n;
	endfunction

	// results leave the device only for a memory or host register destination
	function automatic logic dest_outside(input logic [15:0] ow);
		logic [3:0] op;
		op = ow[3:0];
		// compares, status load and accumulator results stay inside
		dest_outside = ow[10:8] != 3'(ADDR_MODE_REG) && op != OPC_CMP &&
			op != OPC_LOAD_STATUS && op != OPC_DOT && op != OPC_POLY;
	endfunction

	// status word assembled from its field positions; every other bit reads zero
	function automatic logic [31:0] pack_status(input fspi_result_s rs);
		logic [31:0] w;
		w = 32'h0;
		w[SW_TRAP_BIT] = rs.trap;
		w[SW_L_BIT] = 1'b0;
		w[SW_EQ_BIT] = rs.eq;
		w[SW_LT_BIT] = rs.lt;
		w[SW_KIND_BIT] = rs.kind;
		pack_status = w;
	endfunction

	// halfword of the result word that the next 16-bit read collects
	function automatic logic [31:0] res_lane(input logic [31:0] word, input logic wide,
		input logic [2:0] left);
		if (wide)
			res_lane = word;
		else if (left[0])
			res_lane = {16'h0, word[31:16]};
		else
			res_lane = {16'h0, word[15:0]};
	endfunction

	// words the host collects in the result read
	function automatic logic [2:0] res_words(input logic [15:0] ow, input logic wide);
		// result size follows the precision bit
		if (ow[4])
			res_words = wide ? 3'h2 : 3'h4;
		else
			res_words = wide ? 3'h1 : 3'h2;
	endfunction

	logic [1:0] strb_sync_q;
	logic strb_prev_q;
	logic [3:0] st_s1_q, st_s2_q;
	logic [31:0] d_s1_q, d_s2_q;
	logic [1:0] psel_s1_q, psel_s2_q;
	fspi_ph_e ph_q;
	fspi_instr_s ins_q;
	logic [2:0] left_q;
	logic [2:0] exec_cnt_q;
	logic [63:0] opa_q;
	fspi_result_s res_q;
	logic early_q;
	logic pend_q;
	logic [2:0] pulse_q;
	logic [2:0] res_left_q;

	wire logic w32 = psel_s2_q[0];
	wire logic fall = strb_prev_q & ~strb_sync_q[1];
	wire logic rise = ~strb_prev_q & strb_sync_q[1];
	wire logic [3:0] opc = ins_q.opword[3:0];
	wire logic is_cmp = opc == OPC_CMP;
	// a trap-capable opcode must wait for its real outcome before done
	// early done eligibility
	wire logic can_early = ins_q.opword[10:8] == 3'(ADDR_MODE_REG) && !is_cmp &&
		opc != OPC_STORE_STATUS && opc != OPC_ILLEGAL;

	// =================================================================
	// input synchronisers
	// code and lanes pass the same two stages as the strobe, so all three line up
	always_ff @(posedge ref_clk) begin
		strb_sync_q <= {strb_sync_q[0], slave_strobe_n_in};
		strb_prev_q <= strb_sync_q[1];
		st_s1_q <= status_code;
		st_s2_q <= st_s1_q;
		d_s1_q <= data_in;
		d_s2_q <= d_s1_q;
		psel_s1_q <= proto_sel;
		psel_s2_q <= psel_s1_q;
	end

	// =================================================================
	// protocol phase
	// every transfer is taken on the trailing edge of the synchronised strobe;
	// code and lanes are delayed alike, so they are still valid at that point
	// even though the host may change them soon after
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			ph_q <= PH_IDLE;
			ins_q <= '0;
			left_q <= 3'h0;
			exec_cnt_q <= 3'h0;
			opa_q <= '0;
			early_q <= 1'b0;
			pend_q <= 1'b0;
			res_left_q <= 3'h0;
		end else begin
			// pend_q keeps a background run alive after an early done
			if (pend_q && exec_cnt_q == 3'h0)
				pend_q <= 1'b0;
			else if (exec_cnt_q != 3'h0)
				exec_cnt_q <= exec_cnt_q - 3'h1;
			// data latched on trailing edge with code seen at that same trailing edge
			if (rise && st_s2_q == ST_ID) begin
				if (w32) begin
					if (d_s2_q[31:24] == OWN_ID) begin
						ins_q <= '{id: d_s2_q[31:24], opword: {d_s2_q[15:8], d_s2_q[23:16]}};
						ph_q <= PH_OPND;
						left_q <= opnd_words({d_s2_q[15:8], d_s2_q[23:16]}, 1'b1);
					end else
						ph_q <= PH_IDLE;
				end else begin
					if (d_s2_q[7:0] == OWN_ID) begin
						ins_q.id <= d_s2_q[7:0];
						ph_q <= PH_OPWORD;
					end else
						ph_q <= PH_IDLE;
				end
			end else if (rise && st_s2_q == ST_OP) begin
				case (ph_q)
					PH_OPWORD: begin
						ins_q.opword <= {d_s2_q[7:0], d_s2_q[15:8]};
						left_q <= opnd_words({d_s2_q[7:0], d_s2_q[15:8]}, 1'b0);
						ph_q <= PH_OPND;
					end
					PH_OPND: begin
						if (left_q != 3'h0) begin
							// upper word first on 32-bit bus, low halfword first on 16
							if (w32)
								opa_q <= {opa_q[31:0], d_s2_q};
							else
								opa_q <= {d_s2_q[15:0], opa_q[63:16]};
							left_q <= left_q - 3'h1;
						end
					end
					PH_RES: begin
						if (res_left_q != 3'h0)
							res_left_q <= res_left_q - 3'h1;
						if (res_left_q == 3'h1)
							ph_q <= PH_IDLE;
					end
					default: ;
				endcase
			end else if (rise && st_s2_q == ST_STAT && ph_q == PH_STAT) begin
				// status must stand until the strobe ends, so the phase moves on the rise
				// result read only when no trap and result leaves the device
				if (!res_q.trap && dest_outside(ins_q.opword)) begin
					ph_q <= PH_RES;
					res_left_q <= res_words(ins_q.opword, w32);
				end else
					ph_q <= PH_IDLE;
			end else begin
				case (ph_q)
					PH_OPND: begin
						// execution waits for the last operand and any prior instruction
						if (left_q == 3'h0 && !pend_q) begin
							exec_cnt_q <= 3'(EXEC_CYCLES);
							early_q <= can_early;
							ph_q <= PH_EXEC;
						end
					end
					PH_EXEC: begin
						// the next start waits on pend_q until this run is over
						// early done: signal now, finish in background
						if (early_q) begin
							pend_q <= 1'b1;
							ph_q <= PH_DONE;
						end else if (exec_cnt_q == 3'h1)
							ph_q <= PH_DONE;
					end
					PH_DONE: ph_q <= (w32 && !res_q.trap && !is_cmp) ?
						(dest_outside(ins_q.opword) ? PH_RES : PH_IDLE) : PH_STAT;
					default: ;
				endcase
				if (ph_q == PH_DONE && w32 && !res_q.trap && !is_cmp)
					res_left_q <= res_words(ins_q.opword, 1'b1);
			end
		end
	end

	// =================================================================
	// execution outcome and status word

	// 16-bit halfwords shift in from the top, 32-bit words from the bottom,
	// so the first operand sits at opposite ends of the shift register
	wire logic [31:0] opnd_first = w32 ? opa_q[63:32] : opa_q[31:0];
	wire logic [31:0] opnd_second = w32 ? opa_q[31:0] : opa_q[63:32];
	// outcome is captured at execution start; no real arithmetic runs here
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			res_q <= '{word: SW_RESET, trap: 1'b0, kind: 1'b0, eq: 1'b0, lt: 1'b0};
			accumulator_reg <= '0;
		end else if (ph_q == PH_OPND && left_q == 3'h0 && !pend_q) begin
			res_q.word <= opnd_first;
			// illegal opcode traps with kind bit set
			res_q.trap <= opc == OPC_ILLEGAL;
			res_q.kind <= opc == OPC_ILLEGAL;
			res_q.eq <= is_cmp && opnd_second == opnd_first;
			res_q.lt <= is_cmp && $signed(opnd_second) < $signed(opnd_first);
			// accumulator, width from the precision bit
			if (opc == OPC_DOT || opc == OPC_POLY)
				accumulator_reg <= ins_q.opword[4] ? opa_q : {32'h0, opnd_first};
		end
	end

	wire logic [31:0] status_word = pack_status(res_q);

	// =================================================================
	// completion signalling
	always_ff @(posedge ref_clk) begin
		if (sys_rst)
			pulse_q <= 3'h0;
		else if (ph_q == PH_DONE)
			// long variant-A pulse for trap or compare
			pulse_q <= (res_q.trap || is_cmp) ? 3'(SDN_A_LONG_HALF) : 3'h1;
		else if (pulse_q != 3'h0)
			pulse_q <= pulse_q - 3'h1;
	end

	// half-clock widths approximated in whole clocks on a single clock
	// variant A: one clock for a clean finish, three for the long form
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			slave_strobe_n_out <= 1'b1;
			slave_strobe_oe <= 1'b0;
			done_pulse_variant_a_n <= 1'b1;
			done_pulse_variant_b_n <= 1'b1;
			forced_status_read_n <= 1'b1;
		end else begin
			slave_strobe_n_out <= !(ph_q == PH_DONE && !w32);
			slave_strobe_oe <= ph_q == PH_DONE && !w32;
			// variant A low in the done cycle and while counter is above 3
			// done cycle plus two counter steps gives three clocks in all
			done_pulse_variant_a_n <= !(psel_s2_q == PSEL_A &&
				(ph_q == PH_DONE || pulse_q > 3'h3));
			// one clock on variant B lines
			done_pulse_variant_b_n <= !(psel_s2_q == PSEL_B && ph_q == PH_DONE &&
				!res_q.trap && !is_cmp);
			forced_status_read_n <= !(psel_s2_q == PSEL_B && ph_q == PH_DONE &&
				(res_q.trap || is_cmp));
		end
	end

	// =================================================================
	// read data path
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			data_out <= '0;
			data_oe <= 1'b0;
		end else if (!strb_sync_q[1] && st_s2_q == ST_STAT && ph_q == PH_STAT) begin
			// status word, zeroed after early done
			data_out <= early_q ? 32'h0 : status_word;
			data_oe <= 1'b1;
		end else if (!strb_sync_q[1] && st_s2_q == ST_OP && ph_q == PH_RES) begin
			// 16-bit results go out a halfword at a time, low half first
			data_out <= res_lane(res_q.word, w32, res_left_q);
			data_oe <= 1'b1;
		end else begin
			// zero while idle so the shared lanes never carry stale status
			data_out <= '0;
			data_oe <= 1'b0;
		end
	end
endmodule

// >>> testbench/fspi_chk.sv
// output assertions for the coprocessor slave port
`timescale 1ns/1ps
module fspi_chk
	import fspi_pkg::*;
(
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic [1:0] proto_sel,
	input wire logic slave_strobe_n_in,
	input wire logic slave_strobe_n_out,
	input wire logic slave_strobe_oe,
	input wire logic [3:0] status_code,
	input wire logic [31:0] data_in,
	input wire logic [31:0] data_out,
	input wire logic data_oe,
	input wire logic done_pulse_variant_a_n,
	input wire logic done_pulse_variant_b_n,
	input wire logic forced_status_read_n,
	input wire logic [63:0] accumulator_reg
);
	// =====================================================================
	// assertions
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (sys_rst);
	a_strobe_one_clk: assert property ($fell(slave_strobe_n_out) |=> slave_strobe_n_out)
		else $error("completion strobe not one clock wide");
	a_strobe_mode: assert property (!slave_strobe_n_out |-> slave_strobe_oe && proto_sel == PSEL_16)
		else $error("completion strobe outside 16-bit mode");
	a_strobe_input_32: assert property (proto_sel != PSEL_16 |-> !slave_strobe_oe)
		else $error("strobe driven in a 32-bit mode");
	a_done_b_one: assert property ($fell(done_pulse_variant_b_n) |=> done_pulse_variant_b_n)
		else $error("variant b done not one clock");
	a_forced_status_read_one_clk: assert property ($fell(forced_status_read_n) |=> forced_status_read_n)
		else $error("forced status read not one clock");
	a_b_lines_mode: assert property (!done_pulse_variant_b_n |-> forced_status_read_n && proto_sel == PSEL_B)
		else $error("variant b done misplaced");
	a_a_width: assert property ($fell(done_pulse_variant_a_n) |=> done_pulse_variant_a_n or (!done_pulse_variant_a_n [*2] ##1 done_pulse_variant_a_n))
		else $error("variant a done width wrong");
	a_a_mode: assert property (!done_pulse_variant_a_n |-> proto_sel == PSEL_A)
		else $error("variant a done outside its mode");
	a_data_idle: assert property (!data_oe |-> data_out == 32'h0000_0000)
		else $error("read data not cleared while idle");
	cover property ($fell(slave_strobe_n_out));
	cover property ($fell(forced_status_read_n));
	cover property (!done_pulse_variant_a_n [*3]);
endmodule

bind fspi_slave fspi_chk u_chk (.ref_clk(ref_clk), .sys_rst(sys_rst), .proto_sel(proto_sel),
	.slave_strobe_n_in(slave_strobe_n_in), .slave_strobe_n_out(slave_strobe_n_out),
	.slave_strobe_oe(slave_strobe_oe), .status_code(status_code), .data_in(data_in),
	.data_out(data_out), .data_oe(data_oe), .done_pulse_variant_a_n(done_pulse_variant_a_n),
	.done_pulse_variant_b_n(done_pulse_variant_b_n),
	.forced_status_read_n(forced_status_read_n), .accumulator_reg(accumulator_reg));

// >>> testbench/fspi_host.sv
// host side model: slave strobe, status code and data lanes
`timescale 1ns/1ps
module fspi_host (
	input wire logic ref_clk,
	output logic strobe_n,
	output logic [3:0] code,
	output logic [31:0] data,
	input wire logic [31:0] rdata
);
	initial begin
		strobe_n = 1'b1;
		code = 4'h0;
		data = 32'hffff_ffff;
	end
	// =====================================================================
	// one strobed cycle
	// code and data stay put past the strobe rise so the synchronisers see them
	task automatic xfer(input logic [3:0] c, input logic [31:0] d, output logic [31:0] r);
		@(negedge ref_clk);
		code = c;
		data = d;
		strobe_n = 1'b0;
		repeat (5) @(negedge ref_clk);
		r = rdata;
		strobe_n = 1'b1;
		repeat (3) @(negedge ref_clk);
		data = ~d;
	endtask
endmodule

// >>> testbench/testbench.sv
// self-checking bench for the coprocessor slave port
`timescale 1ns/1ps
module testbench;
	import fspi_pkg::*;
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [1:0] proto_sel = PSEL_16;
	logic h_stb_n, s_out_n, s_oe, d_oe, da_n, db_n, fs_n;
	logic [3:0] code;
	logic [31:0] h_d, d_out, bus, r;
	logic [63:0] acc;
	int n_errors = 0;
	int checks = 0;
	logic [31:0] tab [3][3] = '{'{32'h5, 32'h5, 32'h40}, '{32'h5, 32'h3, 32'h80}, '{32'h5, 32'h9, 32'h0}};
	wire logic stb_n = s_oe ? s_out_n : h_stb_n;
	wire logic [3:0] evt = {~fs_n, ~db_n, ~da_n, ~stb_n & s_oe};
	assign bus = d_oe ? d_out : h_d;
	always #4 ref_clk = ~ref_clk;
	fspi_slave dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .proto_sel(proto_sel),
		.slave_strobe_n_in(stb_n), .slave_strobe_n_out(s_out_n), .slave_strobe_oe(s_oe),
		.status_code(code), .data_in(bus), .data_out(d_out), .data_oe(d_oe),
		.done_pulse_variant_a_n(da_n), .done_pulse_variant_b_n(db_n),
		.forced_status_read_n(fs_n), .accumulator_reg(acc));
	fspi_host host (.ref_clk(ref_clk), .strobe_n(h_stb_n), .code(code), .data(h_d), .rdata(bus));
	// =====================================================================
	// tasks
	task automatic give_verdict();
		$display("checks %0d errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic do_reset(input logic [1:0] p);
		@(negedge ref_clk);
		sys_rst = 1'b1;
		proto_sel = p;
		repeat (20) @(negedge ref_clk);
		sys_rst = 1'b0;
		repeat (4) @(negedge ref_clk);
	endtask
	task automatic wait_evt(input int w);
		for (int i = 0; i < 80 && evt[w] !== 1'b1; i++)
			@(negedge ref_clk);
		chk("completion seen", 32'h1, {31'h0, evt[w] === 1'b1});
		if (evt[w] !== 1'b1)
			give_verdict();
	endtask
	task automatic quiet(input int w);
		logic [31:0] hit = 32'h0;
		for (int i = 0; i < 40; i++) begin
			@(negedge ref_clk);
			if (evt[w] !== 1'b0)
				hit = 32'h1;
		end
		chk("no completion", 32'h0, hit);
	endtask
	// ID on lane 0, then the swapped operation word
	task automatic issue16(input logic [7:0] id, input logic [15:0] op);
		host.xfer(ST_ID, {24'h0, id}, r);
		host.xfer(ST_OP, {16'h0, op[7:0], op[15:8]}, r);
	endtask
	// single operand as two halfwords, least significant first
	task automatic opnd16(input logic [31:0] v);
		host.xfer(ST_OP, {16'h0, v[15:0]}, r);
		host.xfer(ST_OP, {16'h0, v[31:16]}, r);
	endtask
	task automatic rd(input logic [3:0] c, input logic [31:0] e, input string nm);
		host.xfer(c, 32'h0, r);
		chk(nm, e, r);
	endtask
	// =====================================================================
	// main sequence
	initial begin
		do_reset(PSEL_16);
		foreach (tab[k]) begin
			issue16(ID_DEFAULT, 16'h0122);
			opnd16(tab[k][0]);
			quiet(0);
			opnd16(tab[k][1]);
			wait_evt(0);
			rd(ST_STAT, tab[k][2], "compare status");
		end
		issue16(ID_DEFAULT, 16'h0128);
		opnd16(32'h1357_2468);
		opnd16(32'h0000_0002);
		wait_evt(0);
		rd(ST_STAT, 32'h0, "dot status");
		chk("accumulator low", 32'h1357_2468, acc[31:0]);
		chk("accumulator high", 32'h0, acc[63:32]);
		issue16(ID_DEFAULT, 16'h000f);
		wait_evt(0);
		rd(ST_STAT, 32'h0000_8001, "trap status");
		issue16(ID_DEFAULT, 16'h0000);
		wait_evt(0);
		rd(ST_STAT, 32'h0, "early done status");
		issue16(ID_DEFAULT, 16'h0120);
		opnd16(32'h5678_1234);
		opnd16(32'h0000_0001);
		wait_evt(0);
		rd(ST_STAT, 32'h0, "clean status");
		host.xfer(ST_OP, 32'h0, r);
		chk("result low half", 32'h1234, {16'h0, r[15:0]});
		host.xfer(ST_OP, 32'h0, r);
		chk("result high half", 32'h5678, {16'h0, r[15:0]});
		issue16(8'h11, 16'h0000);
		quiet(0);
		issue16(ID_DEFAULT, 16'h0122);
		opnd16(32'h1);
		issue16(ID_DEFAULT, 16'h000f);
		wait_evt(0);
		rd(ST_STAT, 32'h0000_8001, "status after cancel");
		for (int v = 0; v < 2; v++) begin
			do_reset(v ? PSEL_B : PSEL_A);
			host.xfer(ST_ID, {ID_DEFAULT, 8'h22, 8'h01, 8'h00}, r);
			host.xfer(ST_OP, 32'h7, r);
			host.xfer(ST_OP, 32'h2, r);
			wait_evt(v ? 3 : 1);
			@(negedge ref_clk);
			chk("long done", v ? 32'h0 : 32'h1, {31'h0, evt[v ? 3 : 1]});
			rd(ST_STAT, 32'h80, "32-bit compare status");
			host.xfer(ST_ID, {ID_DEFAULT, 24'h0}, r);
			wait_evt(v ? 2 : 1);
			@(negedge ref_clk);
			chk("short done", 32'h0, {31'h0, evt[v ? 2 : 1]});
		end
		give_verdict();
	end
endmodule
